// >>> include/irqep_pkg.sv
// Holds the register map, field layouts and reset values of the
// interrupt enable and priority block.
// Assumes a 32-bit AHB-Lite bus with one word per register.
package irqep_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_EN0  = 8'h00;
  localparam logic [7:0] OFF_EN1  = 8'h04;
  localparam logic [7:0] OFF_EN2  = 8'h08;
  localparam logic [7:0] OFF_EN3  = 8'h0c;
  localparam logic [7:0] OFF_EN4  = 8'h10;
  localparam logic [7:0] OFF_PRI0 = 8'h14;
  localparam logic [7:0] OFF_PRI1 = 8'h18;
  localparam logic [7:0] OFF_PRI2 = 8'h1c;
  localparam logic [7:0] OFF_STAT = 8'h20;
  localparam logic [7:0] OFF_MASK = 8'h24;
  localparam logic [7:0] OFF_REQ  = 8'h28;

  // ----------------------------------------------------------------
  // Implemented bits and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] EN0_MASK      = 16'h0003;
  localparam logic [15:0] EN1_MASK      = 16'h381f;
  localparam logic [15:0] EN1_TIMER45   = 16'h1800;
  localparam logic [15:0] EN2_MASK      = 16'h0020;
  localparam logic [15:0] EN3_MASK      = 16'hc200;
  localparam logic [15:0] EN4_MASK      = 16'h2003;
  localparam logic [15:0] EN4_FAULT_B   = 16'h0001;
  localparam logic [15:0] PRI0_MASK     = 16'h7777;
  localparam logic [15:0] PRI1_MASK     = 16'h7770;
  localparam logic [15:0] PRI2_MASK     = 16'h7777;
  localparam logic [15:0] EN_RESET      = 16'h0000;
  localparam logic [15:0] PRI_RESET     = 16'h4444;

  // ----------------------------------------------------------------
  // Counts, event bits and request readback layout
  // ----------------------------------------------------------------
  localparam int unsigned NUM_EN    = 5;
  localparam int unsigned NUM_PRI   = 3;
  localparam int unsigned NUM_SLOTS = 12;
  localparam int unsigned NUM_EV    = 2;
  localparam int unsigned EV_NEW    = 0;
  localparam int unsigned EV_RAISE  = 1;
  localparam int unsigned REQ_SRC_LSB   = 4;
  localparam int unsigned REQ_VALID_BIT = 8;

endpackage

// >>> hdl/irqep_top.sv
// Interrupt enable and priority registers with an AHB-Lite slave,
// a prioritised request output and an event interrupt.
// Assumes flags and pre-gated requests come from logic on I_MCLK.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none

module irqep_top #(
  parameter bit TIMER45_PRESENT = 1'b1,
  parameter bit FAULT_B_PRESENT = 1'b1
) (
  // Clock and reset
  input  wire logic        I_MCLK,
  input  wire logic        I_RST_N,
  // AHB-Lite slave
  input  wire logic        I_HSEL,
  input  wire logic [31:0] I_HADDR,
  input  wire logic [1:0]  I_HTRANS,
  input  wire logic        I_HWRITE,
  input  wire logic [2:0]  I_HSIZE,
  input  wire logic [31:0] I_HWDATA,
  input  wire logic        I_HREADY,
  output logic      [31:0] O_HRDATA,
  output logic             O_HREADYOUT,
  output logic             O_HRESP,
  // Source flags and gated outputs
  input  wire logic [79:0] I_FLAG,
  input  wire logic [11:0] I_PRIO_REQ,
  output logic      [79:0] O_FORWARD,
  // Prioritised request and event interrupt
  output logic             O_IRQ_VALID,
  output logic      [2:0]  O_IRQ_LEVEL,
  output logic      [3:0]  O_IRQ_SRC,
  output logic             O_IRQ
);

  // ----------------------------------------------------------------
  // Implemented-bit masks
  // ----------------------------------------------------------------
  // second enable layout
  // fifth enable layout
  // Masks are fixed at elaboration, so a missing source costs no flop.
  localparam logic [15:0] EN1_M = irqep_pkg::EN1_MASK
    & ~(TIMER45_PRESENT ? 16'h0000 : irqep_pkg::EN1_TIMER45);
  localparam logic [15:0] EN4_M = irqep_pkg::EN4_MASK
    & ~(FAULT_B_PRESENT ? 16'h0000 : irqep_pkg::EN4_FAULT_B);
  // Packed with register k in bits 16k+15..16k, the layout of I_FLAG.
  localparam logic [4:0][15:0] EN_M = {EN4_M, irqep_pkg::EN3_MASK,
    irqep_pkg::EN2_MASK, EN1_M, irqep_pkg::EN0_MASK};
  localparam logic [2:0][15:0] PRI_M = {irqep_pkg::PRI2_MASK,
    irqep_pkg::PRI1_MASK, irqep_pkg::PRI0_MASK};

  // The source index port is four bits wide.
  if (irqep_pkg::NUM_SLOTS > 16) begin : g_bad_slots
    $error("Too many priority slots for a four-bit source index.");
  end

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic        wr_ph;
  logic [7:0]  wr_addr;
  logic [4:0][15:0] en;
  logic [4:0][15:0] next_en;
  logic [2:0][15:0] pri;
  logic [2:0][15:0] next_pri;
  logic [1:0]  ev_status;
  logic [1:0]  next_status;
  logic [1:0]  ev_mask;
  logic [1:0]  next_mask;
  logic [1:0]  ev_set;
  logic [31:0] rd_mux;
  logic [2:0]  best_lvl;
  logic [3:0]  best_src;
  logic        best_valid;

  // An address phase is taken only when the bus is ready.
  // Reads of any size answer; only whole-word writes change state.
  wire addr_ph  = I_HSEL & I_HTRANS[1] & I_HREADY;
  wire hi_zero  = (I_HADDR[31:8] == 24'h000000);
  wire is_word  = (I_HSIZE == 3'b010);
  wire rd_take  = addr_ph & ~I_HWRITE;
  wire wr_take  = addr_ph & I_HWRITE & is_word & hi_zero;
  wire [7:0] ra = I_HADDR[7:0];
  wire [31:0] wd = I_HWDATA;
  wire wr_stat  = wr_ph & (wr_addr == irqep_pkg::OFF_STAT);
  wire wr_mask  = wr_ph & (wr_addr == irqep_pkg::OFF_MASK);

  // Write address is held over into the data phase.
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      wr_ph   <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_ph   <= wr_take;
      wr_addr <= ra;
    end
  end

  // ----------------------------------------------------------------
  // Enable and priority registers
  // ----------------------------------------------------------------
  // Each register decodes its own offset from the held write address.
  for (genvar i = 0; i < irqep_pkg::NUM_EN; i++) begin : g_en
    wire hit = wr_ph & (wr_addr == irqep_pkg::OFF_EN0 + 8'(4 * i));
    // masked write store
    // Unimplemented positions never take a one, so they read zero.
    assign next_en[i] = hit ? (wd[15:0] & EN_M[i]) : en[i];
  end

  // Priority writes drop the gap bits, so slot 4 never gains a level.
  for (genvar i = 0; i < irqep_pkg::NUM_PRI; i++) begin : g_pri
    wire hit = wr_ph & (wr_addr == irqep_pkg::OFF_PRI0 + 8'(4 * i));
    assign next_pri[i] = hit ? (wd[15:0] & PRI_M[i]) : pri[i];
  end

  // levels reset four
  // Reset leaves every flag gated off and every slot but slot 4 at a middle level.
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      en  <= {irqep_pkg::NUM_EN{irqep_pkg::EN_RESET}};
      pri <= {irqep_pkg::PRI_RESET & irqep_pkg::PRI2_MASK,
              irqep_pkg::PRI_RESET & irqep_pkg::PRI1_MASK,
              irqep_pkg::PRI_RESET & irqep_pkg::PRI0_MASK};
    end else begin
      en  <= next_en;
      pri <= next_pri;
    end
  end

  // ----------------------------------------------------------------
  // Flag gating
  // ----------------------------------------------------------------
  // flags meet gates
  // bit positions mapped
  // Flags share I_MCLK, so no synchroniser is needed here.
  wire [79:0] gated = I_FLAG & en;
  wire [79:0] en_flat = en;

  // O_FORWARD is registered, so it lags I_FLAG and the enables by one cycle.
  // forward enabled flag
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_FORWARD <= 80'h0;
    end else begin
      O_FORWARD <= gated;
    end
  end

  // ----------------------------------------------------------------
  // Priority slots
  // ----------------------------------------------------------------
  // Slots 0 and 1 share their gate with enable register 0; the rest
  // arrive already gated by enables held elsewhere.
  // Slot 4 has no field and never requests, whatever I_PRIO_REQ[4] shows.
  wire [11:0] slot_raw = {I_PRIO_REQ[11:2], gated[1:0]};
  logic [11:0][2:0] slot_lvl;
  logic [11:0] slot_req;

  for (genvar s = 0; s < irqep_pkg::NUM_SLOTS; s++) begin : g_slot
    assign slot_lvl[s] = pri[s / 4][4 * (s % 4) +: 3];
    assign slot_req[s] = slot_raw[s] & (slot_lvl[s] != 3'b000);
  end

  // linear level compare
  // Strict compare lets the lowest slot win a tie.
  always_comb begin
    best_lvl   = 3'b000;
    best_src   = 4'h0;
    best_valid = 1'b0;
    for (int s = 0; s < irqep_pkg::NUM_SLOTS; s++) begin
      if (slot_req[s] && (slot_lvl[s] > best_lvl)) begin
        best_lvl   = slot_lvl[s];
        best_src   = 4'(s);
        best_valid = 1'b1;
      end
    end
  end

  // Request outputs are registered to keep the bus paths short.
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_IRQ_VALID <= 1'b0;
      O_IRQ_LEVEL <= 3'b000;
      O_IRQ_SRC   <= 4'h0;
    end else begin
      O_IRQ_VALID <= best_valid;
      O_IRQ_LEVEL <= best_lvl;
      O_IRQ_SRC   <= best_src;
    end
  end

  // ----------------------------------------------------------------
  // Event status, mask and interrupt
  // ----------------------------------------------------------------
  // A new request, or a rise in the winning level, sets a sticky bit.
  // A fall in level while valid sets nothing; software polls the request word.
  assign ev_set[irqep_pkg::EV_NEW]   = best_valid & ~O_IRQ_VALID;
  assign ev_set[irqep_pkg::EV_RAISE] = best_valid & O_IRQ_VALID
                                     & (best_lvl > O_IRQ_LEVEL);
  // Set wins over a write-one clear in the same cycle.
  assign next_status = ev_set
    | (ev_status & ~(wr_stat ? wd[1:0] : 2'b00));
  assign next_mask   = wr_mask ? wd[1:0] : ev_mask;
  wire   irq_any     = |(ev_status & ev_mask);

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ev_status <= 2'b00;
      ev_mask   <= 2'b00;
      O_IRQ     <= 1'b0;
    end else begin
      ev_status <= next_status;
      ev_mask   <= next_mask;
      O_IRQ     <= irq_any;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Reads use next_ values so a write just before is seen at once.
  // Unmapped offsets fall to the default and read as zero.
  wire [31:0] req_word = {23'h0, O_IRQ_VALID, O_IRQ_SRC,
                          1'b0, O_IRQ_LEVEL};
  always_comb begin
    rd_mux = 32'h0;
    if (hi_zero) begin
      unique case (ra)
        irqep_pkg::OFF_EN0:  rd_mux = {16'h0, next_en[0]};
        irqep_pkg::OFF_EN1:  rd_mux = {16'h0, next_en[1]};
        irqep_pkg::OFF_EN2:  rd_mux = {16'h0, next_en[2]};
        irqep_pkg::OFF_EN3:  rd_mux = {16'h0, next_en[3]};
        irqep_pkg::OFF_EN4:  rd_mux = {16'h0, next_en[4]};
        irqep_pkg::OFF_PRI0: rd_mux = {16'h0, next_pri[0]};
        irqep_pkg::OFF_PRI1: rd_mux = {16'h0, next_pri[1]};
        irqep_pkg::OFF_PRI2: rd_mux = {16'h0, next_pri[2]};
        irqep_pkg::OFF_STAT: rd_mux = {30'h0, next_status};
        irqep_pkg::OFF_MASK: rd_mux = {30'h0, next_mask};
        irqep_pkg::OFF_REQ:  rd_mux = req_word;
        default:             rd_mux = 32'h0;
      endcase
    end
  end

  // Zero wait states and an OKAY answer for every transfer.
  // HREADYOUT is high in reset too, so the bus never stalls on this slave.
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_HRDATA    <= 32'h0;
      O_HREADYOUT <= 1'b1;
      O_HRESP     <= 1'b0;
    end else begin
      O_HRDATA    <= rd_take ? rd_mux : 32'h0;
      O_HREADYOUT <= 1'b1;
      O_HRESP     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Helpers: the first cycle after reset and last cycle's slot requests.
  logic        first_cyc;
  logic [11:0] last_req;
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      first_cyc <= 1'b1;
      last_req  <= 12'h000;
    end else begin
      first_cyc <= 1'b0;
      last_req  <= slot_req;
    end
  end
  wire [79:0] en_mask_flat = EN_M;
  wire [47:0] pri_mask_flat = PRI_M;
  wire [47:0] pri_flat = pri;

  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_N);

  a_forward_enabled: assert property (
    ##1 O_FORWARD == ($past(I_FLAG) & $past(en_flat)))
    else $error("Forwarded flags differ from flag and enable.");
  a_blocked_disabled: assert property (
    ##1 (O_FORWARD & ~$past(en_flat)) == 80'h0)
    else $error("A disabled source was forwarded.");
  a_unimpl_stay_zero: assert property (
    (en_flat & ~en_mask_flat) == 80'h0 && (pri_flat & ~pri_mask_flat) == 48'h0)
    else $error("An unimplemented bit holds a one.");
  a_reset_values_ok: assert property (
    first_cyc |-> en_flat == 80'h0 && pri_flat == (pri_mask_flat & {3{irqep_pkg::PRI_RESET}}))
    else $error("Registers left reset with wrong values.");
  a_winner_field_lvl: assert property (
    O_IRQ_VALID && $stable(pri_flat) |-> O_IRQ_LEVEL == slot_lvl[O_IRQ_SRC])
    else $error("Request level differs from its field.");
  a_zero_never_wins: assert property (
    O_IRQ_VALID |-> O_IRQ_LEVEL != 3'b000)
    else $error("A zero level was presented.");
  a_request_has_cause: assert property (
    O_IRQ_VALID |-> last_req[O_IRQ_SRC])
    else $error("Request without flag, gate and level.");
  a_en1_write_mask: assert property (
    wr_ph && wr_addr == irqep_pkg::OFF_EN1 |=> en[1] == ($past(I_HWDATA[15:0]) & EN1_M))
    else $error("Second enable register stored a wrong value.");
  a_irq_follows_mask: assert property (
    ##1 O_IRQ == $past(irq_any))
    else $error("Interrupt output does not follow status and mask.");
  a_bus_always_okay: assert property (
    O_HREADYOUT && !O_HRESP)
    else $error("Bus answer was not a ready OKAY.");

  // Status, read-path and request checks; a_set_beats_clear guards the set-wins choice.
  a_status_sticky: assert property (
    !$past(wr_stat) |-> (ev_status & $past(ev_status)) == $past(ev_status))
    else $error("A status bit fell without a clear.");
  a_set_beats_clear: assert property (
    ev_set != 2'b00 |=> (ev_status & $past(ev_set)) == $past(ev_set))
    else $error("A status event was lost.");
  a_data_one_cycle: assert property (
    !rd_take |=> O_HRDATA == 32'h0)
    else $error("Read data stood outside its data phase.");
  a_unmapped_zero: assert property (
    rd_take && ra > irqep_pkg::OFF_REQ |=> O_HRDATA == 32'h0)
    else $error("An unmapped read returned ones.");
  a_pri1_gap_zero: assert property (
    rd_take && hi_zero && ra == irqep_pkg::OFF_PRI1 |=> O_HRDATA[3:0] == 4'h0)
    else $error("Second priority register showed a level in its gap.");
  a_valid_any_req: assert property (
    O_IRQ_VALID == |last_req)
    else $error("Request valid disagrees with the slot requests.");

  c_forward_seen: cover property (|O_FORWARD);
  c_level_seven: cover property (O_IRQ_VALID && O_IRQ_LEVEL == 3'b111);
  c_event_irq: cover property (O_IRQ ##1 !O_IRQ);
  c_write_read: cover property (wr_ph ##1 rd_take);
  c_level_raise: cover property (ev_set[irqep_pkg::EV_RAISE]);

endmodule // irqep_top

`default_nettype wire

// >>> bench/irqep_top_tb.sv
// Self-checking bench for the interrupt enable and priority block.
// Assumes one AHB-Lite slave, so the bus ready is the slave's own ready.
`timescale 1ns/100ps
`default_nettype none

module irqep_top_tb;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic        mclk      = 1'b0;
  logic        rst_n     = 1'b0;
  logic        hsel      = 1'b0;
  logic [31:0] haddr     = 32'h0;
  logic [1:0]  htrans    = 2'h0;
  logic        hwrite    = 1'b0;
  logic [2:0]  hsize     = 3'h2;
  logic [31:0] hwdata    = 32'h0;
  logic [79:0] flag      = 80'h0;
  logic [11:0] prio_req  = 12'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [79:0] fwd;
  logic        irq_valid;
  logic [2:0]  irq_level;
  logic [3:0]  irq_src;
  logic        irq;
  int          mismatches = 0;
  int          checked    = 0;
  int          cycles     = 0;

  // Register map walked by the table scenarios, in bus order.
  localparam logic [7:0]  ADDR_TAB [8] = '{irqep_pkg::OFF_EN0, irqep_pkg::OFF_EN1, irqep_pkg::OFF_EN2,
    irqep_pkg::OFF_EN3, irqep_pkg::OFF_EN4, irqep_pkg::OFF_PRI0, irqep_pkg::OFF_PRI1, irqep_pkg::OFF_PRI2};
  localparam logic [15:0] MASK_TAB [8] = '{irqep_pkg::EN0_MASK, irqep_pkg::EN1_MASK, irqep_pkg::EN2_MASK,
    irqep_pkg::EN3_MASK, irqep_pkg::EN4_MASK, irqep_pkg::PRI0_MASK, irqep_pkg::PRI1_MASK, irqep_pkg::PRI2_MASK};

  irqep_top dut_u (
    .I_MCLK(mclk), .I_RST_N(rst_n), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
    .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata), .I_HREADY(hreadyout), .O_HRDATA(hrdata),
    .O_HREADYOUT(hreadyout), .O_HRESP(hresp), .I_FLAG(flag), .I_PRIO_REQ(prio_req), .O_FORWARD(fwd),
    .O_IRQ_VALID(irq_valid), .O_IRQ_LEVEL(irq_level), .O_IRQ_SRC(irq_src), .O_IRQ(irq)
  );

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  // The ceiling is far above the 150 or so cycles the tests need.
  always #25 mclk = ~mclk;

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches = mismatches + 1;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Compare one value; wide enough for the forwarded flag vector.
  task automatic chk(input string name, input logic [79:0] exp, input logic [79:0] got);
    checked = checked + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One single word transfer; entered and left just after a rising edge.
  task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    hsize  <= 3'h2;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] rd;
    bus_xfer(1'b1, a, {16'hffff, d}, rd);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    bus_xfer(1'b0, a, 32'h0, rd);
    chk(name, {48'h0, exp}, {48'h0, rd});
  endtask

  // Outputs follow inputs one edge later; three edges leave margin for the event path.
  task automatic settle();
    repeat (3) @(posedge mclk);
  endtask

  task automatic chk_req(input logic v, input logic [2:0] lvl, input logic [3:0] src);
    chk("request valid", {79'h0, v}, {79'h0, irq_valid});
    chk("request level", {77'h0, lvl}, {77'h0, irq_level});
    chk("request source", {76'h0, src}, {76'h0, irq_src});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset_values();
    for (int i = 0; i < 8; i++) begin
      rd_chk("reset value", ADDR_TAB[i], {16'h0, (i < 5 ? irqep_pkg::EN_RESET : irqep_pkg::PRI_RESET) & MASK_TAB[i]});
    end
    rd_chk("status reset", irqep_pkg::OFF_STAT, 32'h0);
    chk("response", 80'h0, {79'h0, hresp});
    $display("test reset_values done");
  endtask

  // Ones written to each enable and priority register come back only on implemented bits; unmapped space reads zero.
  task automatic test_write_masks();
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_TAB[i], 16'hffff);
      rd_chk("implemented bits", ADDR_TAB[i], {16'h0, MASK_TAB[i]});
    end
    wr(8'h80, 16'hffff);
    rd_chk("unmapped read", 8'h80, 32'h0);
    $display("test write_masks done");
  endtask

  // Every flag raised; enables decide which reach the forwarded outputs.
  task automatic test_forward();
    flag <= {80{1'b1}};
    settle();
    chk("forward enabled", {irqep_pkg::EN4_MASK, irqep_pkg::EN3_MASK, irqep_pkg::EN2_MASK,
        irqep_pkg::EN1_MASK, irqep_pkg::EN0_MASK}, fwd);
    for (int i = 0; i < 5; i++) wr(ADDR_TAB[i], 16'h0);
    settle();
    chk("forward blocked", 80'h0, fwd);
    flag <= 80'h0;
    $display("test forward done");
  endtask

  // Level selection over slot 0, slot 1 and one pre-gated slot.
  task automatic test_priority();
    wr(irqep_pkg::OFF_EN0, 16'h0003);
    wr(irqep_pkg::OFF_PRI0, 16'h0017);
    wr(irqep_pkg::OFF_PRI2, 16'h6000);
    flag <= 80'h3;
    settle();
    chk_req(1'b1, 3'h7, 4'h0);
    wr(irqep_pkg::OFF_PRI0, 16'h0010);
    settle();
    chk_req(1'b1, 3'h1, 4'h1);
    prio_req <= 12'h800;
    settle();
    chk_req(1'b1, 3'h6, 4'hb);
    rd_chk("request word", irqep_pkg::OFF_REQ,
           (32'h1 << irqep_pkg::REQ_VALID_BIT) | (32'hb << irqep_pkg::REQ_SRC_LSB) | 32'h6);
    rd_chk("status events", irqep_pkg::OFF_STAT, 32'h3);
    prio_req <= 12'h0;
    wr(irqep_pkg::OFF_EN0, 16'h0001);
    settle();
    chk_req(1'b0, 3'h0, 4'h0);
    flag <= 80'h0;
    wr(irqep_pkg::OFF_PRI0, 16'h4444);
    $display("test priority done");
  endtask

  // A new request sets a sticky status bit; the mask gates the line, a one clears it.
  task automatic test_event_irq();
    wr(irqep_pkg::OFF_EN0, 16'h0001);
    wr(irqep_pkg::OFF_MASK, 16'h0003);
    rd_chk("mask readback", irqep_pkg::OFF_MASK, 32'h3);
    flag <= 80'h1;
    settle();
    chk("irq unmasked", 80'h1, {79'h0, irq});
    flag <= 80'h0;
    settle();
    rd_chk("status sticky", irqep_pkg::OFF_STAT, 32'h1);
    wr(irqep_pkg::OFF_STAT, 16'h0003);
    settle();
    rd_chk("status cleared", irqep_pkg::OFF_STAT, 32'h0);
    chk("irq cleared", 80'h0, {79'h0, irq});
    wr(irqep_pkg::OFF_MASK, 16'h0000);
    flag <= 80'h1;
    settle();
    chk("irq masked", 80'h0, {79'h0, irq});
    flag <= 80'h0;
    wr(irqep_pkg::OFF_STAT, 16'h0003);
    $display("test event_irq done");
  endtask

  // An asynchronous reset in mid-run puts written registers back to their reset values.
  task automatic test_mid_reset();
    wr(irqep_pkg::OFF_EN0, 16'h0003);
    wr(irqep_pkg::OFF_PRI0, 16'h7777);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd_chk("enable after reset", irqep_pkg::OFF_EN0, {16'h0, irqep_pkg::EN_RESET & irqep_pkg::EN0_MASK});
    rd_chk("priority after reset", irqep_pkg::OFF_PRI0, {16'h0, irqep_pkg::PRI_RESET & irqep_pkg::PRI0_MASK});
    $display("test mid_reset done");
  endtask

  // ----------------------------------------------------------------
  // Closing report and main sequence
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    test_reset_values();
    test_event_irq();
    test_priority();
    test_write_masks();
    test_forward();
    test_mid_reset();
    finish_test();
  end
endmodule // irqep_top_tb

`default_nettype wire
